// ### rtl/adc_ctrl_map.svh
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// Register addresses (word index on the plain register port)
`define ADDR_CONTROL_ONE 4'h0
`define ADDR_CONTROL_TWO 4'h1
`define ADDR_IRQ_STATUS 4'h2
`define ADDR_IRQ_MASK 4'h3
`define ADDR_RESULT 4'h4
`define ADDR_DMA_ADDRESS 4'h5

// Control one fields
`define C1_ON 15
`define C1_IDLE_STOP 13
`define C1_DMA_BUILD 12
`define C1_RES_SEL 10
`define C1_FORM_HI 9
`define C1_FORM_LO 8
`define C1_TRIG_HI 7
`define C1_TRIG_LO 5
`define C1_TRIG_GROUP 4
`define C1_SIMULTANEOUS_SAMPLE 3
`define C1_AUTO 2
`define C1_SAMPLE 1
`define C1_DONE 0
`define C1_WRITE_MASK 16'hB7FE

// Control two fields
`define C2_REF_HI 15
`define C2_REF_LO 13
`define C2_SCAN 10
`define C2_CHPS_HI 9
`define C2_CHPS_LO 8
`define C2_BUFFER_HALF_STATUS 7
`define C2_SMPI_HI 6
`define C2_SMPI_LO 2
`define C2_SPLIT_BUFFER_MODE 1
`define C2_ALTERNATE_INPUT 0
`define C2_WRITE_MASK 16'hE77F

// Interrupt status bits
`define IRQ_DONE 0
`define IRQ_GROUP 1

`define RESET_VALUE 16'h0000

// Sample time before conversion starts, in auto and manual sampling alike
`define SAMPLE_TIME_NS 100
`define CLK_PERIOD_NS 4
`define SAMPLE_CYCLES ((`SAMPLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_type;

  // Request to the converter core
  typedef struct packed {
    logic start;
    logic [1:0] channel;
    logic [3:0] scan_input;
    logic twelve_bit;
    logic [2:0] reference;
    logic alternate;
  } core_request_type;

  // DMA side output
  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic [15:0] address;
  } dma_write_type;

endpackage

// ### rtl/adc_control_registers.sv
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"

module adc_control_registers #(
  parameter int DMA_BUF_SIZE_LOG2 = 4,
  parameter logic [15:0] SCAN_SELECT = 16'h000F
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic idle_mode,
  input wire logic trigger_in,
  output adc_ctrl_pkg::core_request_type core_request,
  input wire logic core_done,
  input wire logic [11:0] core_result,
  output adc_ctrl_pkg::dma_write_type dma_write,
  output logic irq
);

  logic [15:0] ctl1_q;
  logic [15:0] ctl2_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  logic [15:0] result_q;
  logic [15:0] dma_addr_q;
  logic [4:0] conv_count_q;
  logic [1:0] chan_q;
  logic [3:0] scan_q;
  logic buffer_half_status_q;
  logic [7:0] sample_control_cnt_q;
  adc_ctrl_pkg::conv_state_type state_q;
  logic [15:0] formatted;
  logic [15:0] ctl2_view;
  logic run;
  logic twelve;
  logic [1:0] form;
  logic [1:0] last_chan;
  logic group_end;
  logic wr1;
  logic wr2;
  logic next_q;

  assign twelve = ctl1_q[`C1_RES_SEL];
  assign form = ctl1_q[`C1_FORM_HI:`C1_FORM_LO];
  assign wr1 = reg_write && (reg_addr == `ADDR_CONTROL_ONE);
  assign wr2 = reg_write && (reg_addr == `ADDR_CONTROL_TWO);

  // Converter allowed to run when on and not stopped by idle
  assign run = ctl1_q[`C1_ON] && !(ctl1_q[`C1_IDLE_STOP] && idle_mode);

  // Last channel of a multi-channel sample
  always_comb begin
    if (twelve) begin
      last_chan = 2'h0;
    end else if (ctl2_q[`C2_CHPS_HI]) begin
      last_chan = 2'h3;
    end else if (ctl2_q[`C2_CHPS_LO]) begin
      last_chan = 2'h1;
    end else begin
      last_chan = 2'h0;
    end
  end

  // Result formatting per resolution and format code
  always_comb begin
    formatted = 16'h0000;
    if (twelve) begin
      unique case (form)
        2'b00: formatted = {4'h0, core_result};
        2'b01: formatted = {{4{~core_result[11]}}, ~core_result[11],
          core_result[10:0]};
        2'b10: formatted = {core_result, 4'h0};
        2'b11: formatted = {~core_result[11], core_result[10:0], 4'h0};
      endcase
    end else begin
      unique case (form)
        2'b00: formatted = {6'h00, core_result[9:0]};
        2'b01: formatted = {{6{~core_result[9]}}, ~core_result[9],
          core_result[8:0]};
        2'b10: formatted = {core_result[9:0], 6'h00};
        2'b11: formatted = {~core_result[9], core_result[8:0], 6'h00};
      endcase
    end
  end

  // Group of conversions completes after count value plus one
  assign group_end = core_done && (state_q == adc_ctrl_pkg::ST_CONVERT)
    && (chan_q == last_chan)
    && (conv_count_q == ctl2_q[`C2_SMPI_HI:`C2_SMPI_LO]);

  // Control register one, sample and done bits shared with hardware
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl1_q <= `RESET_VALUE;
    end else begin
      if (wr1) begin
        ctl1_q <= (reg_wdata & `C1_WRITE_MASK)
          | (ctl1_q & ~`C1_WRITE_MASK);
        if (!reg_wdata[`C1_DONE]) begin
          ctl1_q[`C1_DONE] <= 1'b0;
        end
      end
      if (state_q == adc_ctrl_pkg::ST_SAMPLE
          && sample_control_cnt_q == 8'(`SAMPLE_CYCLES)) begin
        ctl1_q[`C1_SAMPLE] <= 1'b0;
      end
      if (run && ctl1_q[`C1_AUTO] && state_q == adc_ctrl_pkg::ST_IDLE) begin
        ctl1_q[`C1_SAMPLE] <= 1'b1;
      end
      if (state_q == adc_ctrl_pkg::ST_SAMPLE && !run) begin
        ctl1_q[`C1_SAMPLE] <= 1'b0;
      end
      if (core_done && state_q == adc_ctrl_pkg::ST_CONVERT) begin
        ctl1_q[`C1_DONE] <= 1'b1;
      end
    end
  end

  // Control register two, buffer status read only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl2_q <= `RESET_VALUE;
    end else if (wr2) begin
      ctl2_q <= reg_wdata & `C2_WRITE_MASK;
    end
  end

  // Sample and convert sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= adc_ctrl_pkg::ST_IDLE;
      sample_control_cnt_q <= 8'h00;
      chan_q <= 2'h0;
    end else if (!run) begin
      state_q <= adc_ctrl_pkg::ST_IDLE;
      sample_control_cnt_q <= 8'h00;
      chan_q <= 2'h0;
    end else begin
      unique case (state_q)
        adc_ctrl_pkg::ST_IDLE: begin
          sample_control_cnt_q <= 8'h00;
          chan_q <= 2'h0;
          if (ctl1_q[`C1_SAMPLE] || trigger_in) begin
            state_q <= adc_ctrl_pkg::ST_SAMPLE;
          end
        end
        adc_ctrl_pkg::ST_SAMPLE: begin
          sample_control_cnt_q <= sample_control_cnt_q + 8'h01;
          if (sample_control_cnt_q == 8'(`SAMPLE_CYCLES)) begin
            state_q <= adc_ctrl_pkg::ST_CONVERT;
          end
        end
        adc_ctrl_pkg::ST_CONVERT: begin
          if (core_done) begin
            if (chan_q == last_chan) begin
              state_q <= adc_ctrl_pkg::ST_IDLE;
              chan_q <= 2'h0;
            end else begin
              chan_q <= chan_q + 2'h1;
            end
          end
        end
      endcase
    end
  end

  // Scan input pointer steps through selected inputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scan_q <= 4'h0;
    end else if (!ctl2_q[`C2_SCAN]) begin
      scan_q <= 4'h0;
    end else if (core_done && state_q == adc_ctrl_pkg::ST_CONVERT
                 && chan_q == 2'h0) begin
      for (int i = 1; i <= 16; i++) begin
        if (SCAN_SELECT[4'(scan_q + 4'(i))] && i <= 16) begin
          scan_q <= 4'(scan_q + 4'(i));
          break;
        end
      end
    end
  end

  // Conversion counter, buffer half and DMA address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_count_q <= 5'h00;
      buffer_half_status_q <= 1'b0;
      dma_addr_q <= 16'h0000;
    end else if (core_done && state_q == adc_ctrl_pkg::ST_CONVERT
                 && chan_q == last_chan) begin
      if (group_end) begin
        conv_count_q <= 5'h00;
        if (ctl2_q[`C2_SPLIT_BUFFER_MODE]) begin
          buffer_half_status_q <= ~buffer_half_status_q;
        end
        if (ctl1_q[`C1_DMA_BUILD]) begin
          dma_addr_q <= dma_addr_q + 16'h0001;
        end
      end else begin
        conv_count_q <= conv_count_q + 5'h01;
      end
    end
  end

  // Result register and DMA write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      result_q <= 16'h0000;
      dma_write <= '0;
    end else begin
      dma_write.valid <= 1'b0;
      if (core_done && state_q == adc_ctrl_pkg::ST_CONVERT) begin
        result_q <= formatted;
        dma_write.valid <= 1'b1;
        dma_write.data <= formatted;
        if (ctl1_q[`C1_DMA_BUILD]) begin
          dma_write.address <= dma_addr_q;
        end else begin
          dma_write.address <= 16'((ctl2_q[`C2_SCAN] ?
            {12'h000, scan_q} : {14'h0000, chan_q}) << DMA_BUF_SIZE_LOG2)
            | {11'h000, conv_count_q};
        end
      end
    end
  end

  // Sticky interrupt status, set wins over write-one clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_status_q <= 2'b00;
      irq_mask_q <= 2'b00;
    end else begin
      if (reg_write && reg_addr == `ADDR_IRQ_MASK) begin
        irq_mask_q <= reg_wdata[1:0];
      end
      irq_status_q <= (irq_status_q
        & ~((reg_write && reg_addr == `ADDR_IRQ_STATUS) ?
            reg_wdata[1:0] : 2'b00))
        | {group_end, core_done && state_q == adc_ctrl_pkg::ST_CONVERT};
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // Control two as read, channel count hidden in 12-bit mode
  always_comb begin
    ctl2_view = ctl2_q;
    ctl2_view[`C2_BUFFER_HALF_STATUS] = buffer_half_status_q && ctl2_q[`C2_SPLIT_BUFFER_MODE];
    if (twelve) begin
      ctl2_view[`C2_CHPS_HI:`C2_CHPS_LO] = 2'b00;
    end
  end

  // Read data one cycle after the read strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      unique case (reg_addr)
        `ADDR_CONTROL_ONE: reg_rdata <= ctl1_q;
        `ADDR_CONTROL_TWO: reg_rdata <= ctl2_view;
        `ADDR_IRQ_STATUS: reg_rdata <= {14'h0000, irq_status_q};
        `ADDR_IRQ_MASK: reg_rdata <= {14'h0000, irq_mask_q};
        `ADDR_RESULT: reg_rdata <= result_q;
        `ADDR_DMA_ADDRESS: reg_rdata <= dma_addr_q;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Restart the core for the next channel of a multi-channel group
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      next_q <= 1'b0;
    end else begin
      next_q <= run && core_done && (state_q == adc_ctrl_pkg::ST_CONVERT)
        && (chan_q != last_chan);
    end
  end

  // Request toward the converter core, one pulse per channel
  assign core_request.start = ((state_q == adc_ctrl_pkg::ST_SAMPLE)
    && (sample_control_cnt_q == 8'(`SAMPLE_CYCLES)))
    || (next_q && (state_q == adc_ctrl_pkg::ST_CONVERT));
  assign core_request.channel = chan_q;
  assign core_request.scan_input = scan_q;
  assign core_request.twelve_bit = twelve;
  assign core_request.reference = ctl2_q[`C2_REF_HI:`C2_REF_LO];
  assign core_request.alternate = ctl2_q[`C2_ALTERNATE_INPUT];

endmodule // adc_control_registers

// ### bench/adc_core_model.sv
`timescale 1ns/1ps
module adc_core_model (
  input wire logic clk,
  input wire logic reset,
  input wire adc_ctrl_pkg::core_request_type core_request,
  input wire logic [11:0] result_in,
  input wire logic slow,
  output logic core_done,
  output logic [11:0] core_result
);
  logic [5:0] wait_q;
  logic busy_q;
  // One conversion per start, answered quickly or slowly
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      wait_q <= 6'h00;
      core_done <= 1'b0;
    end else begin
      core_done <= busy_q && wait_q == 6'h00;
      if (core_request.start) begin
        busy_q <= 1'b1;
        wait_q <= slow ? 6'h28 : 6'h01;
      end else if (wait_q != 6'h00) begin
        wait_q <= wait_q - 6'h01;
      end else begin
        busy_q <= 1'b0;
      end
    end
  end
  // Result lines carry junk outside the done cycle
  assign core_result = core_done ? result_in : ~result_in;
endmodule // adc_core_model

// ### bench/adc_control_registers_asserts.sv
`timescale 1ns/1ps
module adc_ctrl_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic idle_mode,
  input wire adc_ctrl_pkg::core_request_type core_request,
  input wire logic core_done,
  input wire adc_ctrl_pkg::dma_write_type dma_write
);
  logic [15:0] c1_q;
  logic [15:0] c2_q;
  // Shadow of the written control words
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c1_q <= 16'h0000;
      c2_q <= 16'h0000;
    end else if (reg_write && reg_addr == 4'h0) begin
      c1_q <= reg_wdata;
    end else if (reg_write && reg_addr == 4'h1) begin
      c2_q <= reg_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Software kick of sampling, and the end of sampling
  sequence kick_s;
    reg_write && reg_addr == 4'h0 && reg_wdata[15] && reg_wdata[1] &&
      !(reg_wdata[13] && idle_mode);
  endsequence
  sequence start_s;
    core_request.start;
  endsequence
  start_pulse_a: assert property (start_s |=> !core_request.start)
    else $error("start too long");
  start_on_a: assert property (start_s |-> c1_q[15])
    else $error("start while off");
  idle_halt_a: assert property (
    c1_q[13] && idle_mode && $past(idle_mode) |-> !core_request.start)
    else $error("start in idle");
  kick_start_a: assert property (kick_s |-> ##[24:27] start_s)
    else $error("sampling never ended");
  res_follow_a: assert property (core_request.twelve_bit == c1_q[10])
    else $error("resolution mismatch");
  ref_follow_a: assert property (
    core_request.reference == c2_q[15:13] &&
      core_request.alternate == c2_q[0])
    else $error("reference mismatch");
  ch_zero_a: assert property (
    start_s and core_request.twelve_bit |-> core_request.channel == 2'h0)
    else $error("12-bit channel not zero");
  dma_done_a: assert property (core_done |=> dma_write.valid)
    else $error("result not handed on");
  dma_cause_a: assert property (dma_write.valid |-> $past(core_done))
    else $error("stray dma write");
  spare_zero_a: assert property (
    $past(reg_read && reg_addr == 4'h0) |->
      reg_rdata[14] == 1'b0 && reg_rdata[11] == 1'b0)
    else $error("spare bit set");
endmodule // adc_ctrl_checker
bind adc_control_registers adc_ctrl_checker chk_u (.clk, .reset,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .idle_mode,
  .core_request, .core_done, .dma_write);

// ### bench/tb_adc_control_registers.sv
`timescale 1ns/1ps
module tb_adc_control_registers;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic idle_mode = 1'b0;
  logic slow = 1'b0;
  logic [11:0] res_in = 12'h000;
  logic [11:0] v;
  logic rd_d = 1'b0;
  logic [15:0] reg_rdata;
  logic core_done, irq;
  logic [11:0] core_result;
  adc_ctrl_pkg::core_request_type core_request;
  adc_ctrl_pkg::dma_write_type dma_write;
  logic [15:0] rd_q[$];
  logic [15:0] dma_q[$];
  int mismatches = 0;
  int compares = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  adc_control_registers dut_u (.clk, .reset, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .idle_mode, .trigger_in(1'b0),
    .core_request, .core_done, .core_result, .dma_write, .irq);
  adc_core_model core_u (.clk, .reset, .core_request, .result_in(res_in),
    .slow, .core_done, .core_result);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // Read, noting the word expected in the next cycle
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk);
    reg_read <= 1'b0;
  endtask
  // Bounded wait for all noted results
  task automatic drain;
    for (int i = 0; i < 3000 && dma_q.size() > 0; i++)
      @(posedge clk);
    if (dma_q.size() > 0) begin
      mismatches++;
      stop_test();
    end
  endtask
  // Output word for a resolution, format code and raw result
  function automatic logic [15:0] fmt(input logic t, input logic [1:0] f,
    input logic [11:0] r);
    logic [15:0] l;
    logic [15:0] s;
    l = t ? {r, 4'h0} : {r[9:0], 6'h00};
    s = {~l[15], l[14:0]};
    case (f)
      2'h0: return l >> (t ? 4 : 6);
      2'h1: return $signed(s) >>> (t ? 4 : 6);
      2'h2: return l;
      default: return s;
    endcase
  endfunction
  // Monitor: oldest note against each result
  always @(posedge clk) rd_d <= reg_read;
  always @(negedge clk) begin
    if (rd_d)
      check(reg_rdata, rd_q.pop_front());
    if (dma_write.valid === 1'b1)
      check(dma_write.data,
        dma_q.size() > 0 ? dma_q.pop_front() : ~dma_write.data);
  end
  initial begin
    void'($urandom(81631));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // Reset values, unmapped words read zero
    for (int a = 0; a < 16; a++)
      rd(4'(a), 16'h0000);
    // Spare bits, and channel count hidden in 12-bit mode
    wr(4'h0, 16'h77FC);
    rd(4'h0, 16'h37FC);
    wr(4'h1, 16'hFFFF);
    rd(4'h1, 16'hE47F);
    wr(4'h0, 16'h0000);
    // Each format in both resolutions, each channel count in 10-bit mode
    for (int k = 0; k < 8; k++) begin
      v = 12'($urandom);
      res_in <= v;
      slow <= k[0];
      wr(4'h3, {14'h0000, k[1:0]});
      wr(4'h1, {6'h00, k[1:0], 8'h02});
      repeat (k[2] ? 1 : k[1] ? 4 : k[0] + 1)
        dma_q.push_back(fmt(k[2], k[1:0], v));
      wr(4'h0, {1'b1, 4'h0, k[2], k[1:0], 8'h02});
      drain();
      rd(4'h0, {1'b1, 4'h0, k[2], k[1:0], 8'h01});
      rd(4'h2, 16'h0003);
      if (k == 0)
        rd(4'h1, 16'h0082);
      check({15'h0000, irq}, {15'h0000, |k[1:0]});
      wr(4'h2, 16'h0003);
      wr(4'h0, 16'h0000);
      check({15'h0000, irq}, 16'h0000);
    end
    // Idle stop holds the sequence
    idle_mode <= 1'b1;
    wr(4'h0, 16'hA002);
    repeat (60) @(posedge clk);
    rd(4'h2, 16'h0000);
    idle_mode <= 1'b0;
    wr(4'h0, 16'h0000);
    drain();
    stop_test();
  end
endmodule // tb_adc_control_registers
